/* dv/pefs_pad_model.sv */
`timescale 1ns/1ps

module pefs_pad_model (
	// Pad drive from the block.
	input wire logic [15:0] padOut,
	input wire logic [15:0] padOe,
	// Board level on pads that nobody drives.
	input wire logic [15:0] extLvl,
	// Resolved pad level.
	output logic [15:0] padIn
);
	assign padIn = (padOut & padOe) | (extLvl & ~padOe);
endmodule : pefs_pad_model

/* dv/test_port_e_pin_function_select.sv */
`timescale 1ns/1ps
`include "pefs_map.svh"

module test_port_e_pin_function_select;
	import pefs_pkg::*;
	logic clk, waitrequest, serRxd, serSckIn;
	logic rst_n = 1'b0;
	logic read = 1'b0;
	logic write = 1'b0;
	logic [3:0] address = 4'h0;
	logic [3:0] byteenable = 4'h0;
	logic [31:0] writedata = 32'h0;
	logic [31:0] readdata, rd;
	logic [3:0] tmrIn;
	logic [15:0] padIn, padOut, padOe, portIn;
	logic [15:0] portOut = 16'hA5FF;
	logic [15:0] portOe = 16'h0000;
	logic [15:0] extLvl = 16'h5A35;
	pefs_pad_t [3:0] tmrPad = 8'hAA;
	pefs_ser_t serDrv = 3'b011;
	logic emuModeSel_n = 1'b1;
	logic tapTdo = 1'b1;
	logic [4:0] tapPadIn = 5'h05;
	logic [4:0] tapPortOut = 5'h0A;
	logic [4:0] tapPortOe = 5'h1F;
	logic [4:0] tapPadOut, tapPadOe;
	pefs_tap_t tapIn;
	int errors = 0;
	int n_checks = 0;
	logic [2:0] c;
	logic [2:0] codes [3] = '{`PEFS_MD_PORT, `PEFS_MD_TMR, `PEFS_MD_SER};
	logic [1:0] drvE [3] = '{2'b11, 2'b11, 2'b10};
	logic [2:0] oeE [3] = '{3'b111, 3'b000, 3'b110};

	pefs_pin_mux pefs_pin_mux_i (.clk, .rst_n, .address, .read, .write,
		.writedata, .byteenable, .readdata, .waitrequest, .padIn, .padOut,
		.padOe, .portOut, .portOe, .portIn, .tmrPad, .tmrIn, .serDrv, .serRxd,
		.serSckIn, .emuModeSel_n, .tapPadIn, .tapPadOut, .tapPadOe,
		.tapPortOut, .tapPortOe, .tapTdo, .tapIn);
	pefs_pad_model pefs_pad_model_i (.padOut, .padOe, .extLvl, .padIn);

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	task automatic stop_test();
		$display("checks %0d mismatches %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : stop_test

	task automatic chk(input string what, input logic [31:0] seen, exp);
		n_checks++;
		if (seen !== exp) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	task automatic bus(input logic we, input logic [3:0] a,
		input logic [15:0] wd, input logic [3:0] be);
		int i;
		@(posedge clk);
		address <= a;
		write <= we;
		read <= !we;
		writedata <= {16'h0000, wd};
		byteenable <= be;
		for (i = 0; i < 20; i++) begin
			@(posedge clk);
			if (!waitrequest) break;
		end
		rd = readdata;
		read <= 1'b0;
		write <= 1'b0;
		if (i == 20) begin
			$display("[ERR] bus answer expected 0 seen timeout");
			errors++;
			stop_test();
		end
	endtask : bus

	initial begin
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		bus(0, `PEFS_OFS_FNSEL, 0, 4'h3);
		chk("fnsel", rd, 32'h0);
		bus(0, `PEFS_OFS_LEVEL, 0, 4'h3);
		chk("level", rd, {16'h0, extLvl & `PEFS_LEVEL_MASK});
		bus(1, `PEFS_OFS_LEVEL, 16'hFFFF, 4'h3);
		bus(0, `PEFS_OFS_LEVEL, 0, 4'h3);
		chk("level ro", rd, {16'h0, extLvl & `PEFS_LEVEL_MASK});
		$display("test reset done");
		portOe <= 16'hFFFF;
		for (int k = 0; k < 3; k++) begin
			c = codes[k];
			// Reserved bits are set here on purpose to see them read zero.
			bus(1, `PEFS_OFS_FNSEL, {1'b1, c, 1'b1, c, 1'b1, c, 3'b110,
				c == `PEFS_MD_TMR}, 4'h3);
			bus(0, `PEFS_OFS_FNSEL, 0, 4'h3);
			chk("fnsel", rd, {1'b0, c, 1'b0, c, 1'b0, c, 3'b000,
				c == `PEFS_MD_TMR});
			repeat (3) @(posedge clk);
			chk("drive", padOut[3:2], drvE[k]);
			chk("enable", padOe[3:1], oeE[k]);
			chk("rxd", serRxd, c == 3'h6 ? extLvl[1] : 1'b1);
			chk("sck", serSckIn, c == 3'h6 && serDrv.sckDrv);
			chk("port in", portIn, padIn & `PEFS_LEVEL_MASK);
			chk("tmr", tmrIn[3:1], c == 3'h1 ? extLvl[3:1] : 3'h0);
			chk("high pins", padOut[15:8], portOut[15:8]);
			bus(0, `PEFS_OFS_LEVEL, 0, 4'h3);
			chk("level", rd, {16'h0, padIn & `PEFS_LEVEL_MASK});
		end
		$display("test modes done");
		bus(1, `PEFS_OFS_FNSEL, 16'h7773, 4'h3);
		bus(0, `PEFS_OFS_FNSEL, 0, 4'h3);
		chk("prohibited", rd, 32'h6660);
		bus(1, `PEFS_OFS_FNSEL, 16'h1111, 4'h1);
		bus(1, 4'h8, 16'h0011, 4'h3);
		bus(0, 4'h8, 0, 4'h3);
		chk("unmapped", rd, 32'h0);
		bus(0, `PEFS_OFS_FNSEL, 0, 4'h3);
		chk("lanes", rd, 32'h6611);
		$display("test refusals done");
		emuModeSel_n <= 1'b0;
		repeat (3) @(posedge clk);
		chk("tap oe", tapPadOe, 5'h10);
		chk("tdo", tapPadOut[4], tapTdo);
		chk("tap in", tapIn, 4'hA);
		emuModeSel_n <= 1'b1;
		repeat (3) @(posedge clk);
		chk("tap port", {tapPadOe, tapPadOut}, {tapPortOe, tapPortOut});
		chk("tap idle", tapIn, 4'h0);
		$display("test emulator done");
		stop_test();
	end
endmodule : test_port_e_pin_function_select

/* rtl/pefs_map.svh */
`ifndef PEFS_MAP_SVH
`define PEFS_MAP_SVH

// Register byte offsets on the bus.
`define PEFS_OFS_FNSEL 4'h0
`define PEFS_OFS_LEVEL 4'h4

// Pin mode codes.
`define PEFS_MD_PORT 3'h0
`define PEFS_MD_TMR 3'h1
`define PEFS_MD_SER 3'h6

// Mode field positions in the function-select register.
`define PEFS_P0_LSB 0
`define PEFS_P1_LSB 4
`define PEFS_P2_LSB 8
`define PEFS_P3_LSB 12
`define PEFS_P0_MASK 16'h0003
`define PEFS_P1_MASK 16'h0070
`define PEFS_P2_MASK 16'h0700
`define PEFS_P3_MASK 16'h7000

// Writable bits, reset value and readable pad levels.
`define PEFS_FNSEL_WMASK 16'h7773
`define PEFS_FNSEL_RST 16'h0000
`define PEFS_LEVEL_MASK 16'hFF0F

// Idle values handed to peripherals whose pin is not selected.
`define PEFS_RXD_IDLE 1'b1
`define PEFS_SCK_IDLE 1'b0
`define PEFS_TMR_IDLE 4'h0
`define PEFS_TAP_IDLE 4'h0

// Index of the test-data output among the shared test-port pins.
`define PEFS_TDO_PIN 4

// Indices of the test-port input pins among the shared pins.
`define PEFS_TMS_PIN 0
`define PEFS_TRST_PIN 1
`define PEFS_TDI_PIN 2
`define PEFS_TCK_PIN 3

`endif

/* rtl/pefs_pin_mux.sv */
// Implementation choices: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "pefs_map.svh"

// Summary of operation
// RL1 - Pin 3 mode: 000 port, 001 timer ch0 D, 110 serial clock.
// RL2 - Pin 2 mode: 000 port, 001 timer ch0 C, 110 serial transmit.
// RL3 - Pin 1 mode: 000 port, 001 timer ch0 B, 110 serial receive.
// RL4 - Software writes only listed mode codes; others are prohibited.
// RL5 - Reserved select bits 15, 11, 7 read zero; software writes zero.
// RL6 - Level bits return pad level whatever the function; 15:8 and 3:0.
// RL7 - Level bits are read-only; writes leave them unchanged.
// RL8 - Level bits 7 to 4 always read zero.
// RL9 - Pins start as port; selection only among each pin's alternatives.
// RL10 - Emulator select low fixes shared pins to the test port.
// RL11 - All mode fields reset to zero, so pins start as port I/O.
module pefs_pin_mux (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst_n,
	// Avalon-MM slave.
	input wire logic [3:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	output logic [31:0] readdata,
	output logic waitrequest,
	// Port pads.
	input wire logic [15:0] padIn,
	output logic [15:0] padOut,
	output logic [15:0] padOe,
	// Port logic.
	input wire logic [15:0] portOut,
	input wire logic [15:0] portOe,
	output logic [15:0] portIn,
	// Timer channel 0, index 0 to 3 for A to D.
	input wire pefs_pkg::pefs_pad_t [3:0] tmrPad,
	output logic [3:0] tmrIn,
	// Serial channel 0.
	input wire pefs_pkg::pefs_ser_t serDrv,
	output logic serRxd,
	output logic serSckIn,
	// Pins shared with the test port, index 4 is test data out.
	input wire logic emuModeSel_n,
	input wire logic [4:0] tapPadIn,
	output logic [4:0] tapPadOut,
	output logic [4:0] tapPadOe,
	input wire logic [4:0] tapPortOut,
	input wire logic [4:0] tapPortOe,
	input wire logic tapTdo,
	output pefs_pkg::pefs_tap_t tapIn
);
	import pefs_pkg::*;

	logic [15:0] fnSel_r;
	logic [15:0] fnSel_nxt;
	pefs_bus_t busState_r;
	logic waitReq_r;
	logic [31:0] readData_r;
	logic [31:0] readMux;
	logic [15:0] padOut_r;
	logic [15:0] padOe_r;
	logic [15:0] portIn_r;
	logic [3:0] tmrIn_r;
	logic serRxd_r;
	logic serSckIn_r;
	logic [4:0] tapPadOut_r;
	logic [4:0] tapPadOe_r;
	pefs_tap_t tapIn_r;
	logic busReq;
	logic wrCommit;
	logic rdTake;
	pefs_pad_t routed [3:0];
	pefs_pad_t serPad [3:0];
	pefs_pad_t portPad [3:0];

	function automatic logic [2:0] modeOf(input logic [15:0] sel,
		input logic [1:0] pin);
		case (pin)
			2'h0: modeOf = {1'b0, sel[`PEFS_P0_LSB +: 2]};
			2'h1: modeOf = sel[`PEFS_P1_LSB +: 3];
			2'h2: modeOf = sel[`PEFS_P2_LSB +: 3];
			default: modeOf = sel[`PEFS_P3_LSB +: 3];
		endcase
	endfunction : modeOf

	function automatic logic [15:0] fieldMask(input logic [1:0] pin);
		case (pin)
			2'h0: fieldMask = `PEFS_P0_MASK;
			2'h1: fieldMask = `PEFS_P1_MASK;
			2'h2: fieldMask = `PEFS_P2_MASK;
			default: fieldMask = `PEFS_P3_MASK;
		endcase
	endfunction : fieldMask

	// Pin 0 offers only port and timer; pins 1 to 3 add the serial line.
	function automatic logic modeLegal(input logic [2:0] md,
		input logic [1:0] pin);
		modeLegal = (md == `PEFS_MD_PORT) || (md == `PEFS_MD_TMR) ||
			((md == `PEFS_MD_SER) && (pin != 2'h0));
	endfunction : modeLegal

	function automatic pefs_tap_t tapOf(input logic [4:0] pins);
		tapOf = '{tms: pins[`PEFS_TMS_PIN], trst: pins[`PEFS_TRST_PIN],
			tdi: pins[`PEFS_TDI_PIN], tck: pins[`PEFS_TCK_PIN]};
	endfunction : tapOf

	// A field written with a prohibited code keeps its old value.
	function automatic logic [15:0] applyWrite(input logic [15:0] old,
		input logic [15:0] wd, input logic [1:0] be);
		logic [15:0] merged;
		logic [15:0] res;
		logic [15:0] msk;
		merged = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
		res = old;
		for (int p = 0; p < 4; p++) begin
			msk = fieldMask(2'(p));
			if (modeLegal(modeOf(merged, 2'(p)), 2'(p))) begin
				res = (res & ~msk) | (merged & msk);
			end
		end
		applyWrite = res & `PEFS_FNSEL_WMASK;
	endfunction : applyWrite

	assign busReq = read | write;
	assign wrCommit = (busState_r == PEFS_BUS_ANS) && write;
	assign rdTake = (busState_r == PEFS_BUS_WAIT) && read;

	// Every access answers one cycle after it is seen.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			busState_r <= PEFS_BUS_WAIT;
			waitReq_r <= 1'b1;
		end else begin
			case (busState_r)
				PEFS_BUS_WAIT: begin
					if (busReq) begin
						busState_r <= PEFS_BUS_ANS;
						waitReq_r <= 1'b0;
					end
				end
				default: begin
					busState_r <= PEFS_BUS_WAIT;
					waitReq_r <= 1'b1;
				end
			endcase
		end
	end

	always_comb begin
		if (address == `PEFS_OFS_FNSEL) begin
			readMux = {16'h0000, fnSel_r & `PEFS_FNSEL_WMASK}; // [RL5]
		end else if (address == `PEFS_OFS_LEVEL) begin
			readMux = {16'h0000, padIn & `PEFS_LEVEL_MASK}; // [RL6] [RL8]
		end else begin
			readMux = 32'h0000_0000;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			readData_r <= 32'h0000_0000;
		end else if (rdTake) begin
			readData_r <= readMux;
		end
	end

	always_comb begin
		fnSel_nxt = fnSel_r;
		if (wrCommit && (address == `PEFS_OFS_FNSEL)) begin
			fnSel_nxt = applyWrite(fnSel_r, writedata[15:0],
				byteenable[1:0]); // [RL4] [RL9]
		end
	end

	// Level register has no storage, so writes to it do nothing.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			fnSel_r <= `PEFS_FNSEL_RST; // [RL11]
		end else begin
			fnSel_r <= fnSel_nxt; // [RL7]
		end
	end

	always_comb begin
		for (int i = 0; i < 4; i++) begin
			portPad[i] = '{drv: portOut[i], oe: portOe[i]};
		end
		serPad[0] = '{drv: 1'b0, oe: 1'b0};
		serPad[1] = '{drv: 1'b0, oe: 1'b0};
		serPad[2] = '{drv: serDrv.txd, oe: 1'b1};
		serPad[3] = '{drv: serDrv.sckDrv, oe: serDrv.sckOe};
	end

	for (genvar g = 0; g < 4; g++) begin : gRoute
		pefs_pin_route pefs_pin_route_i (
			.mode(modeOf(fnSel_r, 2'(g))), // [RL1] [RL2] [RL3]
			.portPad(portPad[g]),
			.tmrPad(tmrPad[g]),
			.serPad(serPad[g]),
			.pad(routed[g])
		);
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			padOut_r <= 16'h0000;
			padOe_r <= 16'h0000;
		end else begin
			padOut_r[15:8] <= portOut[15:8];
			padOe_r[15:8] <= portOe[15:8];
			padOut_r[7:4] <= 4'h0;
			padOe_r[7:4] <= 4'h0;
			for (int i = 0; i < 4; i++) begin
				padOut_r[i] <= routed[i].drv;
				padOe_r[i] <= routed[i].oe;
			end
		end
	end

	// Timer and serial inputs reach only the owner of the pin, others see idle levels; the port sees every readable pad.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			portIn_r <= 16'h0000;
			tmrIn_r <= `PEFS_TMR_IDLE;
			serRxd_r <= `PEFS_RXD_IDLE;
			serSckIn_r <= `PEFS_SCK_IDLE;
		end else begin
			portIn_r <= padIn & `PEFS_LEVEL_MASK;
			for (int i = 0; i < 4; i++) begin
				tmrIn_r[i] <= (modeOf(fnSel_r, 2'(i)) == `PEFS_MD_TMR) ?
					padIn[i] : 1'b0;
			end
			serRxd_r <= (modeOf(fnSel_r, 2'h1) == `PEFS_MD_SER) ?
				padIn[1] : `PEFS_RXD_IDLE; // [RL3]
			serSckIn_r <= (modeOf(fnSel_r, 2'h3) == `PEFS_MD_SER) ?
				padIn[3] : `PEFS_SCK_IDLE; // [RL1]
		end
	end

	// Test-port pins: emulator mode overrides the port function.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			tapPadOut_r <= 5'h00;
			tapPadOe_r <= 5'h00;
			tapIn_r <= `PEFS_TAP_IDLE;
		end else if (!emuModeSel_n) begin
			tapPadOut_r <= 5'h00;
			tapPadOe_r <= 5'h00;
			tapPadOut_r[`PEFS_TDO_PIN] <= tapTdo; // [RL10]
			tapPadOe_r[`PEFS_TDO_PIN] <= 1'b1; // [RL10]
			tapIn_r <= tapOf(tapPadIn); // [RL10]
		end else begin
			tapPadOut_r <= tapPortOut;
			tapPadOe_r <= tapPortOe;
			tapIn_r <= `PEFS_TAP_IDLE;
		end
	end

	assign readdata = readData_r;
	assign waitrequest = waitReq_r;
	assign padOut = padOut_r;
	assign padOe = padOe_r;
	assign portIn = portIn_r;
	assign tmrIn = tmrIn_r;
	assign serRxd = serRxd_r;
	assign serSckIn = serSckIn_r;
	assign tapPadOut = tapPadOut_r;
	assign tapPadOe = tapPadOe_r;
	assign tapIn = tapIn_r;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence sReadSeen;
		waitrequest && read && (address == `PEFS_OFS_LEVEL);
	endsequence

	sequence sAnswer;
		!waitrequest;
	endsequence

	a_pin3_timer_route: assert property ( // [RL1]
		modeOf(fnSel_r, 2'h3) == `PEFS_MD_TMR |=>
		padOut[3] == $past(tmrPad[3].drv) && padOe[3] == $past(tmrPad[3].oe))
		else $error("pin 3 not driven by timer D");

	a_pin2_serial_tx: assert property ( // [RL2]
		modeOf(fnSel_r, 2'h2) == `PEFS_MD_SER |=>
		padOe[2] && padOut[2] == $past(serDrv.txd))
		else $error("pin 2 not driven by serial transmit");

	a_pin1_serial_rx: assert property ( // [RL3]
		modeOf(fnSel_r, 2'h1) == `PEFS_MD_SER |=>
		!padOe[1] && serRxd == $past(padIn[1]))
		else $error("pin 1 not routed to serial receive");

	a_select_legal_only: assert property ( // [RL9]
		modeLegal(modeOf(fnSel_r, 2'h0), 2'h0) &&
		modeLegal(modeOf(fnSel_r, 2'h1), 2'h1) &&
		modeLegal(modeOf(fnSel_r, 2'h2), 2'h2) &&
		modeLegal(modeOf(fnSel_r, 2'h3), 2'h3))
		else $error("prohibited mode code stored");

	a_reserved_sel_zero: assert property ( // [RL5]
		!waitrequest && address == `PEFS_OFS_FNSEL && read |->
		readdata[15] == 1'b0 && readdata[11] == 1'b0 && readdata[7] == 1'b0)
		else $error("reserved select bit read as one");

	a_level_read_pad: assert property ( // [RL6]
		sReadSeen ##1 sAnswer |->
		readdata[15:8] == $past(padIn[15:8]) &&
		readdata[3:0] == $past(padIn[3:0]))
		else $error("level read differs from pad");

	a_level_reserved_zero: assert property ( // [RL8]
		sReadSeen ##1 sAnswer |-> readdata[7:4] == 4'h0)
		else $error("level bits 7 to 4 not zero");

	a_level_write_noeff: assert property ( // [RL7]
		!waitrequest && write && address == `PEFS_OFS_LEVEL |=>
		$stable(fnSel_r))
		else $error("level write changed state");

	a_reset_port_mode: assert property ( // [RL11]
		$rose(rst_n) |-> fnSel_r == `PEFS_FNSEL_RST ##1
		padOe[3:0] == $past(portOe[3:0]))
		else $error("mode fields not zero after reset");

	a_emu_tap_fixed: assert property ( // [RL10]
		!emuModeSel_n |=> tapPadOe == 5'h10 &&
		tapIn == tapOf($past(tapPadIn)))
		else $error("test port pins not fixed in emulator mode");

	a_bus_one_wait: assert property (
		waitrequest && (read || write) |=> !waitrequest ##1 waitrequest)
		else $error("bus answer not one cycle after request");

endmodule : pefs_pin_mux

/* rtl/pefs_pin_route.sv */
`timescale 1ns/1ps
`include "pefs_map.svh"

module pefs_pin_route (
	// Selected mode of this pin.
	input wire logic [2:0] mode,
	// Candidate drivers.
	input wire pefs_pkg::pefs_pad_t portPad,
	input wire pefs_pkg::pefs_pad_t tmrPad,
	input wire pefs_pkg::pefs_pad_t serPad,
	// Chosen driver.
	output pefs_pkg::pefs_pad_t pad
);
	import pefs_pkg::*;

	// Unlisted codes never reach here; they fall back to port drive.
	always_comb begin
		if (mode == `PEFS_MD_TMR) begin
			pad = tmrPad;
		end else if (mode == `PEFS_MD_SER) begin
			pad = serPad;
		end else begin
			pad = portPad;
		end
	end

endmodule : pefs_pin_route

/* rtl/pefs_pkg.sv */
package pefs_pkg;

	typedef struct packed {
		logic drv;
		logic oe;
	} pefs_pad_t;

	typedef struct packed {
		logic txd;
		logic sckDrv;
		logic sckOe;
	} pefs_ser_t;

	typedef struct packed {
		logic tms;
		logic trst;
		logic tdi;
		logic tck;
	} pefs_tap_t;

	typedef enum logic {
		PEFS_BUS_WAIT,
		PEFS_BUS_ANS
	} pefs_bus_t;

endpackage : pefs_pkg
